// file: src/wrsc_pkg.sv
package wrsc_pkg;
    localparam int  CNT_W      = 35;
    localparam int  CODE_W     = 24;
    localparam int  ID_W       = 16;
    localparam int  RDC_W      = 4;
    localparam int  CLK_KHZ    = 40000;
    // Times in milliseconds
    localparam longint T_LOCK_MS  = 3000;
    localparam longint T_WAKE_MS  = 3000;
    localparam longint T_HOLD_MS  = 3000;
    localparam longint T_SEND_MS  = 1000;
    localparam longint T_PROG_MS  = 5000;
    localparam longint T_BOTH_MS  = 2000;
    localparam longint T_BLINK_MS = 250;
    localparam longint T_IDLE_MS  = 600000;
    localparam longint T_BATT_MS  = 120000;
    // Derived cycle counts
    localparam logic [CNT_W-1:0] C_LOCK  = CNT_W'(T_LOCK_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] C_WAKE  = CNT_W'(T_WAKE_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] C_HOLD  = CNT_W'(T_HOLD_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] C_SEND  = CNT_W'(T_SEND_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] C_PROG  = CNT_W'(T_PROG_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] C_BOTH  = CNT_W'(T_BOTH_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] C_BLINK = CNT_W'(T_BLINK_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] C_IDLE  = CNT_W'(T_IDLE_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] C_BATT  = CNT_W'(T_BATT_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
    localparam logic [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam logic [RDC_W-1:0] READ_LIMIT = 4'hA;
    localparam logic [RDC_W-1:0] RDC_ONE    = 4'h1;
    // Programming card: marker in upper byte, identifier below
    localparam int  PROG_MSB   = CODE_W - 1;
    localparam int  PROG_LSB   = ID_W;
    localparam logic [CODE_W-ID_W-1:0] PROG_MARK = 8'hA8;
    localparam logic [ID_W-1:0] ID_ZERO = 16'h0000;

    typedef enum logic [1:0] {ST_LOCK, ST_RUN, ST_SLEEP} wrsc_state_e;

    typedef struct packed {
        logic              strobe;
        logic              complete;
        logic [CODE_W-1:0] value;
    } wrsc_code_s;

    typedef struct packed {
        logic              valid;
        logic              first;
        logic [CODE_W-1:0] data;
    } wrsc_tx_s;
endpackage : wrsc_pkg

// file: src/wrsc_top.sv
// Notes on behaviour
// - Red 3 s after battery, codes refused
// - Ten idle minutes enter low power
// - Low power: no indicators, no sending
// - Button wakes from low power, red 3 s
// - Low battery: sleep after 2 min/10 reads
// - Red 1 s while sending a code
// - Red 3 s on leaving charging holder
// - Programming card: red 5 s, take identifier
// - Green blinks while any code is read
// - Green and red 2 s after programming
// - Identifier stored, sent first every time
// - Only complete valid codes are sent
`timescale 1ns/1ps
`default_nettype none

module wrsc_sync
(
    // Clock and control
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // Pin in, stable level out
    input  wire logic d,
    output var  logic q
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    wire  agree = (s2_ff == s3_ff);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q     <= 1'b0;
        end
        else if (clk_en)
        begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (agree)
                q <= s3_ff;
        end
    end
endmodule : wrsc_sync

module wrsc_top
    import wrsc_pkg::*;
#(
    parameter logic [CNT_W-1:0] P_LOCK  = C_LOCK,
    parameter logic [CNT_W-1:0] P_WAKE  = C_WAKE,
    parameter logic [CNT_W-1:0] P_HOLD  = C_HOLD,
    parameter logic [CNT_W-1:0] P_SEND  = C_SEND,
    parameter logic [CNT_W-1:0] P_PROG  = C_PROG,
    parameter logic [CNT_W-1:0] P_BOTH  = C_BOTH,
    parameter logic [CNT_W-1:0] P_BLINK = C_BLINK,
    parameter logic [CNT_W-1:0] P_IDLE  = C_IDLE,
    parameter logic [CNT_W-1:0] P_BATT  = C_BATT
)
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // Pins
    input  wire logic             button_pin,
    input  wire logic             in_holder_pin,
    input  wire logic             batt_low_pin,
    // Code sensor
    input  wire logic             code_reading,
    input  wire wrsc_code_s       code_in,
    // Radio link
    input  wire logic             tx_ready,
    output var  wrsc_tx_s         tx_ff,
    // Identifier store
    input  wire logic [ID_W-1:0]  nv_id,
    output var  logic             nv_we_ff,
    output var  logic [ID_W-1:0]  nv_data_ff,
    // Indicators
    output var  logic             led_red_ff,
    output var  logic             led_green_ff
);
    logic              btn_q;
    logic              hold_q;
    logic              batt_q;
    logic              btn_prev_ff;
    logic              hold_prev_ff;
    wrsc_state_e       state_ff;
    logic [CNT_W-1:0]  red_cnt_ff;
    logic [CNT_W-1:0]  both_cnt_ff;
    logic [CNT_W-1:0]  blink_cnt_ff;
    logic [CNT_W-1:0]  idle_cnt_ff;
    logic [RDC_W-1:0]  read_cnt_ff;
    logic              pend_both_ff;
    logic              blink_ff;
    logic              loaded_ff;
    logic [ID_W-1:0]   id_ff;
    logic [CODE_W-1:0] code_hold_ff;

    wrsc_sync u_btn  (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
                      .d(button_pin), .q(btn_q));
    wrsc_sync u_hold (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
                      .d(in_holder_pin), .q(hold_q));
    wrsc_sync u_batt (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
                      .d(batt_low_pin), .q(batt_q));

    // Event decode
    wire run      = (state_ff == ST_RUN);
    wire sleeping = (state_ff == ST_SLEEP);
    wire btn_press = btn_q && !btn_prev_ff;
    wire hold_out  = !hold_q && hold_prev_ff;
    wire is_prog  = (code_in.value[PROG_MSB:PROG_LSB] == PROG_MARK);
    wire good     = code_in.strobe && code_in.complete;
    wire [CNT_W-1:0] idle_lim = batt_q ? P_BATT : P_IDLE;
    wire idle_hit = (idle_cnt_ff >= idle_lim);
    wire read_hit = batt_q && (read_cnt_ff >= READ_LIMIT);
    wire go_sleep = run && !tx_ff.valid && (idle_hit || read_hit);
    // Entering low power refuses a code seen in the same cycle
    wire accept   = run && good && !tx_ff.valid && !go_sleep;
    wire take_prog = accept && is_prog;
    wire send     = accept && !is_prog;
    wire activity = code_in.strobe || code_reading || btn_press
                    || hold_out;
    wire wake     = sleeping && btn_press;
    wire red_end  = (red_cnt_ff == CNT_ONE);
    wire tx_step  = tx_ff.valid && tx_ready;

    // Next red timer, by priority
    wire [CNT_W-1:0] red_dec = (red_cnt_ff != CNT_ZERO) ?
                               red_cnt_ff - CNT_ONE : CNT_ZERO;
    wire [CNT_W-1:0] nxt_red =
        go_sleep  ? CNT_ZERO :
        wake      ? P_WAKE   :
        take_prog ? P_PROG   :
        send      ? P_SEND   :
        (run && hold_out) ? P_HOLD : red_dec;
    wire [CNT_W-1:0] nxt_both =
        go_sleep ? CNT_ZERO :
        (pend_both_ff && red_end) ? P_BOTH :
        (both_cnt_ff != CNT_ZERO) ? both_cnt_ff - CNT_ONE : CNT_ZERO;
    wire blink_wrap = (blink_cnt_ff >= P_BLINK - CNT_ONE);
    wire nxt_red_led = !go_sleep && (nxt_red != CNT_ZERO
                       || nxt_both != CNT_ZERO);
    wire nxt_green_led = !go_sleep && !sleeping &&
                         (nxt_both != CNT_ZERO ||
                          (code_reading && blink_ff));

    wire wrsc_state_e nxt_state =
        (state_ff == ST_LOCK && red_cnt_ff <= CNT_ONE) ? ST_RUN :
        go_sleep ? ST_SLEEP :
        wake     ? ST_RUN   : state_ff;

    wire wrsc_tx_s nxt_tx =
        send ? wrsc_tx_s'{valid: 1'b1, first: 1'b1,
                 data: {{(CODE_W-ID_W){1'b0}}, id_ff}} :
        (tx_step && tx_ff.first) ?
               wrsc_tx_s'{valid: 1'b1, first: 1'b0, data: code_hold_ff} :
        tx_step ? wrsc_tx_s'{valid: 1'b0, first: 1'b0, data: tx_ff.data}
                : tx_ff;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_ff     <= ST_LOCK;
            red_cnt_ff   <= P_LOCK;
            both_cnt_ff  <= CNT_ZERO;
            pend_both_ff <= 1'b0;
            led_red_ff   <= 1'b1;
            led_green_ff <= 1'b0;
            tx_ff        <= '0;
            btn_prev_ff  <= 1'b0;
            hold_prev_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            state_ff     <= nxt_state;
            red_cnt_ff   <= nxt_red;
            both_cnt_ff  <= nxt_both;
            pend_both_ff <= take_prog || (pend_both_ff && !red_end
                            && !go_sleep && !send && !wake);
            led_red_ff   <= nxt_red_led;
            led_green_ff <= nxt_green_led;
            tx_ff        <= nxt_tx;
            btn_prev_ff  <= btn_q;
            hold_prev_ff <= hold_q;
        end
    end

    // Idle, read counting, blink
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            idle_cnt_ff  <= CNT_ZERO;
            read_cnt_ff  <= '0;
            blink_cnt_ff <= CNT_ZERO;
            blink_ff     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!run || activity)
                idle_cnt_ff <= CNT_ZERO;
            else if (!idle_hit)
                idle_cnt_ff <= idle_cnt_ff + CNT_ONE;
            if (wake || !batt_q)
                read_cnt_ff <= '0;
            else if (accept && !read_hit)
                read_cnt_ff <= read_cnt_ff + RDC_ONE;
            if (!code_reading || blink_wrap)
                blink_cnt_ff <= CNT_ZERO;
            else
                blink_cnt_ff <= blink_cnt_ff + CNT_ONE;
            if (!code_reading)
                blink_ff <= 1'b1;
            else if (blink_wrap)
                blink_ff <= !blink_ff;
        end
    end

    // Identifier: restored from store, kept across reset
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            loaded_ff  <= 1'b0;
            nv_we_ff   <= 1'b0;
            nv_data_ff <= ID_ZERO;
        end
        else if (clk_en)
        begin
            loaded_ff <= 1'b1;
            nv_we_ff  <= take_prog;
            if (!loaded_ff)
                id_ff <= nv_id;
            else if (take_prog)
            begin
                id_ff      <= code_in.value[ID_W-1:0];
                nv_data_ff <= code_in.value[ID_W-1:0];
            end
            if (send)
                code_hold_ff <= code_in.value;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    a_lock_no_tx: assert property (state_ff == ST_LOCK |-> !tx_ff.valid)
        else $error("transmit during start-up lockout");
    a_lock_red_on: assert property (
        state_ff == ST_LOCK && $past(state_ff == ST_LOCK) |-> led_red_ff)
        else $error("red off during lockout");
    a_idle_sleep: assert property (
        run && idle_hit && !tx_ff.valid |=> sleeping)
        else $error("idle time did not enter low power");
    a_sleep_quiet: assert property (
        sleeping && $past(sleeping) |->
        !led_red_ff && !led_green_ff && !tx_ff.valid)
        else $error("activity in low power");
    a_wake_red: assert property (
        wake |=> run ##1 led_red_ff)
        else $error("wake did not light red");
    a_batt_reads: assert property (
        run && read_hit && !tx_ff.valid |=> sleeping)
        else $error("low battery read limit ignored");
    a_send_red: assert property (
        send |=> tx_ff.valid ##0 led_red_ff)
        else $error("send without red");
    a_hold_red: assert property (
        run && hold_out && !good |=> led_red_ff)
        else $error("holder removal not shown");
    a_prog_store: assert property (
        take_prog |=> nv_we_ff && id_ff == $past(code_in.value[ID_W-1:0])
        ##1 !nv_we_ff)
        else $error("identifier not taken");
    a_blink_green: assert property (
        !sleeping && !go_sleep && code_reading && blink_ff
        && !$past(sleeping) |=> led_green_ff)
        else $error("green not blinking while reading");
    a_both_leds: assert property (
        run && pend_both_ff && red_end && !send && !go_sleep && !wake
        |=> led_red_ff && led_green_ff)
        else $error("programming done not shown");
    a_id_first: assert property (
        $rose(tx_ff.valid) |-> tx_ff.first &&
        tx_ff.data[ID_W-1:0] == id_ff)
        else $error("identifier not sent first");
    a_bad_code: assert property (
        code_in.strobe && !code_in.complete && !tx_ff.valid
        |=> !tx_ff.valid)
        else $error("incomplete code sent");

    c_send:  cover property (send ##[1:8] (tx_step && !tx_ff.first));
    c_prog:  cover property (take_prog);
    c_sleep: cover property (go_sleep ##[1:100] wake);
endmodule : wrsc_top

`default_nettype wire

// file: bench/wrsc_station.sv
`timescale 1ns/1ps
`default_nettype none

module wrsc_station
    import wrsc_pkg::*;
(
    // Clock and stall control
    input  wire logic              sys_clk,
    input  wire logic              slow,
    // Radio words
    input  wire wrsc_tx_s          tx_ff,
    output var  logic              tx_ready,
    // Captured frames
    output var  logic [CODE_W-1:0] id_word,
    output var  logic [CODE_W-1:0] code_word,
    output var  int                frames,
    output var  logic              bad_order
);
    logic want_id;

    initial
    begin
        tx_ready  = 1'b0;
        frames    = 0;
        bad_order = 1'b0;
        want_id   = 1'b1;
        id_word   = 24'h000000;
        code_word = 24'h000000;
    end

    // Identifier word must lead every frame
    always @(posedge sys_clk)
    begin
        if (tx_ff.valid === 1'b1 && tx_ready)
        begin
            if (tx_ff.first !== want_id) bad_order <= 1'b1;
            if (tx_ff.first) id_word <= tx_ff.data;
            else code_word <= tx_ff.data;
            if (!tx_ff.first) frames <= frames + 1;
            want_id <= !tx_ff.first;
        end
        tx_ready <= #2 slow ? !tx_ready : 1'b1;
    end
endmodule : wrsc_station

`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import wrsc_pkg::*;
    localparam int N_IDLE = 200;
    localparam int N_BATT = 100;
    logic              sys_clk       = 1'b0;
    logic              rst_n         = 1'b0;
    logic              clk_en        = 1'b1;
    logic              button_pin    = 1'b0;
    logic              in_holder_pin = 1'b1;
    logic              batt_low_pin  = 1'b0;
    logic              code_reading  = 1'b0;
    wrsc_code_s        code_in       = '0;
    logic              slow          = 1'b0;
    logic [ID_W-1:0]   nv_id         = 16'h1234;
    logic              tx_ready;
    wrsc_tx_s          tx_ff;
    logic              nv_we_ff;
    logic [ID_W-1:0]   nv_data_ff;
    logic              led_red_ff;
    logic              led_green_ff;
    logic [CODE_W-1:0] id_word;
    logic [CODE_W-1:0] code_word;
    int                frames;
    logic              bad_order;
    int                error_cnt = 0;
    int                tests_run = 0;

    always #12.5 sys_clk = ~sys_clk;

    // Store keeps its value across resets
    always @(posedge sys_clk)
        if (nv_we_ff === 1'b1) nv_id <= nv_data_ff;

    wrsc_top #(.P_LOCK(20), .P_WAKE(20), .P_HOLD(20), .P_SEND(10),
        .P_PROG(30), .P_BOTH(15), .P_BLINK(4), .P_IDLE(N_IDLE),
        .P_BATT(N_BATT)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .clk_en(clk_en), .button_pin(button_pin),
        .in_holder_pin(in_holder_pin), .batt_low_pin(batt_low_pin),
        .code_reading(code_reading), .code_in(code_in),
        .tx_ready(tx_ready), .tx_ff(tx_ff), .nv_id(nv_id),
        .nv_we_ff(nv_we_ff), .nv_data_ff(nv_data_ff),
        .led_red_ff(led_red_ff), .led_green_ff(led_green_ff));

    wrsc_station i_station (.sys_clk(sys_clk), .slow(slow),
        .tx_ff(tx_ff), .tx_ready(tx_ready), .id_word(id_word),
        .code_word(code_word), .frames(frames), .bad_order(bad_order));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : cyc

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic strobe(input logic ok, input logic [CODE_W-1:0] v);
        code_in = '{1'b1, ok, v};
        cyc(1);
        code_in.strobe = 1'b0;
    endtask : strobe

    task automatic wait_frames(input int n);
        for (int k = 0; k < 200 && frames < n; k++) cyc(1);
        if (frames < n)
        begin
            check("frame wait", frames, n);
            end_of_test();
        end
    endtask : wait_frames

    task automatic restart();
        rst_n = 1'b0;
        cyc(16);
        rst_n = 1'b1;
    endtask : restart

    task automatic t_lock();
        cyc(3);
        check("red lock", led_red_ff, 1);
        strobe(1'b1, 24'h000111);
        cyc(26);
        check("red lock end", led_red_ff, 0);
        check("lock frames", frames, 0);
        $display("lock test done");
    endtask : t_lock

    task automatic t_send();
        strobe(1'b0, 24'h000222);
        cyc(6);
        check("incomplete", frames, 0);
        slow = 1'b1;
        strobe(1'b1, 24'h00C0DE);
        cyc(2);
        check("red send", led_red_ff, 1);
        wait_frames(1);
        check("id word", id_word, 24'h001234);
        check("code word", code_word, 24'h00C0DE);
        cyc(12);
        check("red send end", led_red_ff, 0);
        slow = 1'b0;
        $display("send test done");
    endtask : t_send

    task automatic t_prog();
        strobe(1'b1, 24'hA85A5A);
        check("nv write", nv_we_ff, 1);
        check("nv data", nv_data_ff, 16'h5A5A);
        cyc(28);
        check("prog leds", {led_red_ff, led_green_ff}, 2'b10);
        cyc(5);
        check("both leds", {led_red_ff, led_green_ff}, 2'b11);
        cyc(15);
        check("leds off", {led_red_ff, led_green_ff}, 2'b00);
        check("card not sent", frames, 1);
        restart();
        cyc(30);
        strobe(1'b1, 24'h000777);
        wait_frames(2);
        check("new id", id_word, 24'h005A5A);
        check("order", bad_order, 0);
        $display("program test done");
    endtask : t_prog

    task automatic t_green();
        int hi = 0;
        int lo = 0;
        code_reading = 1'b1;
        for (int k = 0; k < 20; k++)
        begin
            cyc(1);
            if (led_green_ff === 1'b1) hi++;
            if (led_green_ff === 1'b0) lo++;
        end
        code_reading = 1'b0;
        check("blink", (hi > 4 && lo > 4), 1);
        cyc(8);
        check("green off", led_green_ff, 0);
        $display("green test done");
    endtask : t_green

    task automatic t_holder();
        in_holder_pin = 1'b0;
        cyc(8);
        check("red holder", led_red_ff, 1);
        clk_en = 1'b0;
        cyc(10);
        check("red frozen", led_red_ff, 1);
        clk_en = 1'b1;
        cyc(10);
        check("red held late", led_red_ff, 1);
        cyc(12);
        check("red holder end", led_red_ff, 0);
        in_holder_pin = 1'b1;
        $display("holder test done");
    endtask : t_holder

    task automatic t_sleep();
        cyc(N_IDLE + 20);
        code_reading = 1'b1;
        strobe(1'b1, 24'h000333);
        cyc(10);
        code_reading = 1'b0;
        check("sleep leds", {led_red_ff, led_green_ff}, 2'b00);
        check("sleep frames", frames, 2);
        button_pin = 1'b1;
        cyc(8);
        check("wake red", led_red_ff, 1);
        button_pin = 1'b0;
        cyc(25);
        strobe(1'b1, 24'h000444);
        wait_frames(3);
        check("awake code", code_word, 24'h000444);
        $display("sleep test done");
    endtask : t_sleep

    task automatic t_batt();
        batt_low_pin = 1'b1;
        cyc(6);
        for (int k = 0; k < 10; k++)
        begin
            strobe(1'b1, CODE_W'(k));
            wait_frames(4 + k);
            cyc(2);
        end
        cyc(15);
        strobe(1'b1, 24'h000555);
        cyc(10);
        check("ten reads", frames, 13);
        button_pin = 1'b1;
        cyc(8);
        button_pin = 1'b0;
        cyc(N_BATT + 20);
        strobe(1'b1, 24'h000666);
        cyc(10);
        check("batt idle", frames, 13);
        $display("battery test done");
    endtask : t_batt

    initial
    begin
        restart();
        t_lock();
        t_send();
        t_prog();
        t_green();
        t_holder();
        t_sleep();
        t_batt();
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
